/* design/hts_pkg.sv */
package hts_pkg;
	localparam int HTS_BYTE_W = 8;
	localparam int HTS_STRAP_W = 5;
	localparam int HTS_ADDR_W = 7;
	// Upper two bits of the slave address are fixed.
	localparam logic [1:0] HTS_ADDR_FIXED = 2'h0;
	localparam logic [7:0] HTS_PTR_RESET = 8'h00;
	localparam logic [6:0] HTS_ADDR_RESET = 7'h00;
	localparam logic HTS_RW_READ = 1'b1;
	localparam logic [3:0] HTS_BITS_PER_BYTE = 4'h8;
	// Clock of both ends and the serial clock quarter period.
	localparam int HTS_CLK_NS = 5;
	localparam int HTS_QUARTER_NS = 650;
	localparam int HTS_QUARTER_CYC = (HTS_QUARTER_NS + HTS_CLK_NS - 1) /
		HTS_CLK_NS;
	// Serial clock ceilings and reset hold kept by the system.
	localparam int HTS_SCL_MAX_KHZ = 400;
	localparam int HTS_SCL_MAX_EXT_KHZ = 100;
	localparam int HTS_RESET_HOLD_MS = 50;
	typedef enum logic [1:0] {
		HTS_OP_START,
		HTS_OP_STOP,
		HTS_OP_WRITE,
		HTS_OP_READ
	} hts_op_t;
endpackage : hts_pkg

/* design/hts_bus_if.sv */
`timescale 1ns/1ps
interface hts_bus_if;
	logic scl_o;
	logic scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic scl;
	logic sda;
	// Open-drain wires: a driver may only pull low; released means high.
	assign scl = ~(scl_oe & ~scl_o);
	assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
	modport host (
		output scl_o,
		output scl_oe,
		output host_sda_o,
		output host_sda_oe,
		input scl,
		input sda
	);
	modport device (
		output dev_sda_o,
		output dev_sda_oe,
		input scl,
		input sda
	);
endinterface : hts_bus_if

/* design/hts_host.sv */
`timescale 1ns/1ps
module hts_host
	import hts_pkg::*;
#(
	parameter int QUARTER_CYC = HTS_QUARTER_CYC
) (
	input wire logic CLOCK,
	input wire logic NRST,
	hts_bus_if.host BUS,
	input wire logic CMD_VALID,
	input wire hts_op_t CMD_OP,
	input wire logic [7:0] CMD_DATA,
	input wire logic CMD_NACK_LAST,
	output logic CMD_READY,
	output logic RSP_VALID,
	output logic [7:0] RSP_DATA,
	output logic RSP_NACK
);
	typedef enum logic [1:0] {H_IDLE, H_START, H_STOP, H_BITS} hts_hstate_t;

	localparam int CW = (QUARTER_CYC > 1) ? $clog2(QUARTER_CYC) : 1;

	hts_hstate_t state_q;
	logic [CW-1:0] div_q;
	logic tick_q;
	logic [1:0] phase_q;
	logic [3:0] bit_q;
	logic [8:0] tx_q;
	logic [8:0] rx_q;
	logic sda_m_q;
	logic sda_s_q;
	logic accept;
	logic done;

	////////////////////////////////////////////////////////////////////////
	// Quarter-period enable that paces the serial clock.
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			div_q <= '0;
			tick_q <= 1'b0;
		end else if (div_q == CW'(QUARTER_CYC - 1)) begin
			div_q <= '0;
			tick_q <= 1'b1;
		end else begin
			div_q <= div_q + 1'b1;
			tick_q <= 1'b0;
		end
	end

	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			sda_m_q <= 1'b1;
			sda_s_q <= 1'b1;
		end else begin
			sda_m_q <= BUS.sda;
			sda_s_q <= sda_m_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign accept = (state_q == H_IDLE) && CMD_VALID && CMD_READY;
	assign done = tick_q && ((state_q == H_START && phase_q == 2'h3) ||
		(state_q == H_STOP && phase_q == 2'h2) ||
		(state_q == H_BITS && phase_q == 2'h3 && bit_q == HTS_BITS_PER_BYTE));

	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			state_q <= H_IDLE;
			CMD_READY <= 1'b1;
			phase_q <= 2'h0;
		end else if (accept) begin
			CMD_READY <= 1'b0;
			phase_q <= 2'h0;
			case (CMD_OP)
				HTS_OP_START: state_q <= H_START;
				HTS_OP_STOP: state_q <= H_STOP;
				default: state_q <= H_BITS;
			endcase
		end else if (done) begin
			state_q <= H_IDLE;
			CMD_READY <= 1'b1;
			phase_q <= 2'h0;
		end else if (tick_q && state_q != H_IDLE) begin
			phase_q <= phase_q + 2'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Line drive. Data bits change only while the serial clock is low; start and stop change data while it is high.
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			BUS.scl_oe <= 1'b0;
			BUS.host_sda_oe <= 1'b0;
			BUS.scl_o <= 1'b0;
			BUS.host_sda_o <= 1'b0;
		end else if (tick_q) begin
			case (state_q)
				H_START: begin
					case (phase_q)
						2'h0: BUS.host_sda_oe <= 1'b0;
						2'h1: BUS.scl_oe <= 1'b0;
						2'h2: BUS.host_sda_oe <= 1'b1;
						default: BUS.scl_oe <= 1'b1;
					endcase
				end
				H_STOP: begin
					case (phase_q)
						2'h0: BUS.host_sda_oe <= 1'b1;
						2'h1: BUS.scl_oe <= 1'b0;
						2'h2: BUS.host_sda_oe <= 1'b0;
						default: BUS.host_sda_oe <= 1'b0;
					endcase
				end
				H_BITS: begin
					case (phase_q)
						2'h0: BUS.host_sda_oe <= ~tx_q[8];
						2'h1: BUS.scl_oe <= 1'b0;
						2'h2: BUS.scl_oe <= 1'b0;
						default: BUS.scl_oe <= 1'b1;
					endcase
				end
				default: BUS.scl_oe <= BUS.scl_oe;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Byte shifting, nine bits with the acknowledge last.
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			tx_q <= 9'h1ff;
			rx_q <= 9'h000;
			bit_q <= 4'h0;
		end else if (accept) begin
			bit_q <= 4'h0;
			if (CMD_OP == HTS_OP_READ) begin
				tx_q <= {8'hff, CMD_NACK_LAST};
			end else begin
				tx_q <= {CMD_DATA, 1'b1};
			end
		end else if (tick_q && state_q == H_BITS) begin
			if (phase_q == 2'h2) begin
				rx_q <= {rx_q[7:0], sda_s_q};
			end
			if (phase_q == 2'h3) begin
				tx_q <= {tx_q[7:0], 1'b1};
				bit_q <= bit_q + 4'h1;
			end
		end
	end

	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			RSP_VALID <= 1'b0;
			RSP_DATA <= 8'h00;
			RSP_NACK <= 1'b0;
		end else begin
			RSP_VALID <= done && state_q == H_BITS;
			if (done && state_q == H_BITS) begin
				RSP_DATA <= rx_q[8:1];
				RSP_NACK <= rx_q[0];
			end
		end
	end
endmodule : hts_host

/* design/hts_device.sv */
`timescale 1ns/1ps
module hts_device
	import hts_pkg::*;
(
	input wire logic CLOCK,
	input wire logic NRST,
	input wire logic [HTS_STRAP_W-1:0] SLAVE_ADDRESS_STRAPS,
	hts_bus_if.device BUS,
	input wire logic [7:0] RD_DATA,
	output logic [7:0] REGISTER_POINTER,
	output logic WR_EN,
	output logic [7:0] WR_ADDR,
	output logic [7:0] WR_DATA,
	output logic [HTS_ADDR_W-1:0] SLAVE_ADDRESS
);
	typedef enum logic [2:0] {
		S_IDLE,
		S_ADDR,
		S_ADDR_ACK,
		S_WRITE,
		S_WR_ACK,
		S_READ,
		S_RD_ACK,
		S_RD_LOAD
	} hts_dstate_t;

	hts_dstate_t state_q;
	logic scl_m_q;
	logic scl_s_q;
	logic scl_p_q;
	logic sda_m_q;
	logic sda_s_q;
	logic sda_p_q;
	logic addr_ok_q;
	logic matched_q;
	logic need_ptr_q;
	logic rw_q;
	logic [HTS_STRAP_W-1:0] strap_m_q;
	logic [HTS_STRAP_W-1:0] strap_s_q;
	logic [3:0] bits_q;
	logic [7:0] rx_q;
	logic [6:0] tx_q;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	logic addr_hit;
	logic wr_byte_done;
	logic rd_load;

	////////////////////////////////////////////////////////////////////////
	// Both bus lines arrive from outside and pass two flops first.
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			scl_m_q <= 1'b1;
			scl_s_q <= 1'b1;
			scl_p_q <= 1'b1;
			sda_m_q <= 1'b1;
			sda_s_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_m_q <= BUS.scl;
			scl_s_q <= scl_m_q;
			scl_p_q <= scl_s_q;
			sda_m_q <= BUS.sda;
			sda_s_q <= sda_m_q;
			sda_p_q <= sda_s_q;
		end
	end

	assign scl_rise = scl_s_q & ~scl_p_q;
	assign scl_fall = ~scl_s_q & scl_p_q;
	assign start_cond = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
	assign stop_cond = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

	////////////////////////////////////////////////////////////////////////
	// Strap pins pass two flops with no reset, so that they already hold
	// the strap levels while reset is still low.
	always_ff @(posedge CLOCK) begin
		strap_m_q <= SLAVE_ADDRESS_STRAPS;
		strap_s_q <= strap_m_q;
	end

	// Address straps are taken on the first clock after reset release.
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			addr_ok_q <= 1'b0;
			SLAVE_ADDRESS <= HTS_ADDR_RESET;
		end else if (!addr_ok_q) begin
			addr_ok_q <= 1'b1;
			SLAVE_ADDRESS <= {HTS_ADDR_FIXED, strap_s_q};
		end
	end

	assign addr_hit = addr_ok_q && (rx_q[7:1] == SLAVE_ADDRESS);
	assign wr_byte_done = scl_fall && state_q == S_WRITE &&
		bits_q == HTS_BITS_PER_BYTE;
	assign rd_load = scl_fall && ((state_q == S_ADDR_ACK && rw_q) ||
		state_q == S_RD_LOAD);

	////////////////////////////////////////////////////////////////////////
	// Bus sequencing. Start and stop override any state.
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			state_q <= S_IDLE;
			bits_q <= 4'h0;
			rw_q <= 1'b0;
			tx_q <= 7'h00;
			BUS.dev_sda_oe <= 1'b0;
			BUS.dev_sda_o <= 1'b0;
		end else if (start_cond) begin
			state_q <= S_ADDR;
			bits_q <= 4'h0;
			BUS.dev_sda_oe <= 1'b0;
		end else if (stop_cond) begin
			state_q <= S_IDLE;
			BUS.dev_sda_oe <= 1'b0;
		end else begin
			case (state_q)
				S_ADDR, S_WRITE: begin
					if (scl_rise) begin
						bits_q <= bits_q + 4'h1;
					end else if (scl_fall && bits_q == HTS_BITS_PER_BYTE) begin
						if (state_q == S_WRITE) begin
							BUS.dev_sda_oe <= 1'b1;
							state_q <= S_WR_ACK;
						end else if (addr_hit) begin
							BUS.dev_sda_oe <= 1'b1;
							rw_q <= rx_q[0];
							state_q <= S_ADDR_ACK;
						end else begin
							state_q <= S_IDLE;
						end
					end
				end
				S_ADDR_ACK, S_RD_LOAD: begin
					if (scl_fall) begin
						bits_q <= 4'h0;
						if (rd_load) begin
							BUS.dev_sda_oe <= ~RD_DATA[7];
							tx_q <= RD_DATA[6:0];
							state_q <= S_READ;
						end else begin
							BUS.dev_sda_oe <= 1'b0;
							state_q <= S_WRITE;
						end
					end
				end
				S_WR_ACK: begin
					if (scl_fall) begin
						BUS.dev_sda_oe <= 1'b0;
						bits_q <= 4'h0;
						state_q <= S_WRITE;
					end
				end
				S_READ: begin
					if (scl_rise) begin
						bits_q <= bits_q + 4'h1;
					end else if (scl_fall) begin
						if (bits_q == HTS_BITS_PER_BYTE) begin
							BUS.dev_sda_oe <= 1'b0;
							state_q <= S_RD_ACK;
						end else begin
							BUS.dev_sda_oe <= ~tx_q[6];
							tx_q <= {tx_q[5:0], 1'b0};
						end
					end
				end
				S_RD_ACK: begin
					if (scl_rise) begin
						// A not-acknowledge leaves the line released.
						state_q <= sda_s_q ? S_IDLE : S_RD_LOAD;
					end
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end

	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			rx_q <= 8'h00;
		end else if (scl_rise && (state_q == S_ADDR || state_q == S_WRITE)) begin
			rx_q <= {rx_q[6:0], sda_s_q};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register pointer and the message-level flags.
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			matched_q <= 1'b0;
		end else if (stop_cond) begin
			matched_q <= 1'b0;
		end else if (scl_fall && state_q == S_ADDR &&
			bits_q == HTS_BITS_PER_BYTE && addr_hit) begin
			matched_q <= 1'b1;
		end
	end

	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			need_ptr_q <= 1'b1;
		end else if (stop_cond && matched_q) begin
			need_ptr_q <= 1'b1;
		end else if (rd_load || wr_byte_done) begin
			need_ptr_q <= 1'b0;
		end
	end

	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			REGISTER_POINTER <= HTS_PTR_RESET;
		end else if (stop_cond && matched_q) begin
			REGISTER_POINTER <= HTS_PTR_RESET;
		end else if (wr_byte_done && need_ptr_q) begin
			REGISTER_POINTER <= rx_q;
		end else if (wr_byte_done || rd_load) begin
			REGISTER_POINTER <= REGISTER_POINTER + 8'h01;
		end
	end

	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			WR_EN <= 1'b0;
			WR_ADDR <= 8'h00;
			WR_DATA <= 8'h00;
		end else begin
			WR_EN <= wr_byte_done && !need_ptr_q;
			if (wr_byte_done && !need_ptr_q) begin
				WR_ADDR <= REGISTER_POINTER;
				WR_DATA <= rx_q;
			end
		end
	end
endmodule : hts_device

/* verification/hts_chk.sv */
`timescale 1ns/1ps
module hts_chk (
	input wire logic CLOCK,
	input wire logic NRST,
	input wire logic scl_o,
	input wire logic scl_oe,
	input wire logic host_sda_o,
	input wire logic host_sda_oe,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!NRST);
	a_rst_release_idle: assert property ($rose(NRST) |->
		!dev_sda_oe && !host_sda_oe && !scl_oe)
		else $error("bus driven after reset");
	a_dev_pull_only: assert property (dev_sda_oe |-> dev_sda_o == 1'b0)
		else $error("device drives data high");
	a_host_pull_only: assert property (host_sda_oe |-> !host_sda_o)
		else $error("host drives data high");
	a_scl_pull_only: assert property (scl_oe |-> !scl_o)
		else $error("host drives clock high");
	a_dev_scl_low: assert property ($changed(dev_sda_oe) |->
		!scl && !$past(scl))
		else $error("device data changed while clock high");
	a_dev_release_bound: assert property ($rose(dev_sda_oe) |->
		##[1:600] !dev_sda_oe)
		else $error("device holds data line too long");
	a_scl_high_min: assert property ($rose(scl) |-> scl [*8])
		else $error("clock high period too short");
	a_scl_low_min: assert property ($fell(scl) |-> !scl [*8])
		else $error("clock low period too short");
endmodule : hts_chk

/* verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top
	import hts_pkg::*;
;
	logic clock, nrst, cmd_valid, cmd_nack, cmd_ready, rsp_valid, rsp_nack;
	logic wr_en;
	hts_op_t cmd_op;
	logic [7:0] cmd_data, rsp_data, ptr, wr_addr, wr_data;
	logic [8:0] sh;
	logic [4:0] straps;
	logic [6:0] slave_addr;
	logic [7:0] mem [256];
	int failures, checks;
	hts_bus_if bus ();
	hts_host #(.QUARTER_CYC(8)) i_hts_host (.CLOCK(clock), .NRST(nrst),
		.BUS(bus), .CMD_VALID(cmd_valid), .CMD_OP(cmd_op),
		.CMD_DATA(cmd_data), .CMD_NACK_LAST(cmd_nack),
		.CMD_READY(cmd_ready), .RSP_VALID(rsp_valid),
		.RSP_DATA(rsp_data), .RSP_NACK(rsp_nack));
	hts_device i_hts_device (.CLOCK(clock), .NRST(nrst),
		.SLAVE_ADDRESS_STRAPS(straps), .BUS(bus), .RD_DATA(mem[ptr]),
		.REGISTER_POINTER(ptr), .WR_EN(wr_en), .WR_ADDR(wr_addr),
		.WR_DATA(wr_data), .SLAVE_ADDRESS(slave_addr));
	hts_chk i_hts_chk (.CLOCK(clock), .NRST(nrst), .scl_o(bus.scl_o),
		.scl_oe(bus.scl_oe), .host_sda_o(bus.host_sda_o),
		.host_sda_oe(bus.host_sda_oe), .dev_sda_o(bus.dev_sda_o),
		.dev_sda_oe(bus.dev_sda_oe), .scl(bus.scl), .sda(bus.sda));
	////////////////////////////////////////////////////////////////////////
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	// Shift in what the wire carries on every serial clock rise.
	always @(posedge bus.scl) sh <= {sh[7:0], bus.sda};
	always @(posedge clock) begin
		if (wr_en === 1'b1) mem[wr_addr] <= wr_data;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [7:0] e,
		input logic [7:0] g);
		checks++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask : chk
	task automatic op(input hts_op_t o, input logic [7:0] d, input logic n);
		int t;
		t = 0;
		while (cmd_ready !== 1'b1 && t < 2000) begin
			@(posedge clock);
			#1;
			t++;
		end
		cmd_valid = 1'b1;
		cmd_op = o;
		cmd_data = d;
		cmd_nack = n;
		@(posedge clock);
		#1;
		cmd_valid = 1'b0;
		if (o == HTS_OP_WRITE || o == HTS_OP_READ) begin
			while (rsp_valid !== 1'b1 && t < 2000) begin
				@(posedge clock);
				#1;
				t++;
			end
		end else begin
			while (cmd_ready !== 1'b1 && t < 2000) begin
				@(posedge clock);
				#1;
				t++;
			end
		end
		// The device sees the lines two to three clocks after the host.
		repeat (4) @(posedge clock);
		#1;
		chk("command completion", 8'h00, {7'h00, t >= 2000});
	endtask : op
	// Write one byte and compare the wire bits and the acknowledge.
	task automatic wr(input logic [7:0] d, input logic nack);
		op(HTS_OP_WRITE, d, 1'b0);
		chk("wire byte", d, sh[8:1]);
		chk("acknowledge", {7'h00, nack}, {7'h00, rsp_nack});
	endtask : wr
	task automatic rd(input logic last, input logic [7:0] e);
		op(HTS_OP_READ, 8'h00, last);
		chk("read data", e, rsp_data);
		chk("wire read byte", e, sh[8:1]);
	endtask : rd
	task automatic results();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : results
	////////////////////////////////////////////////////////////////////////
	initial begin
		#100000;
		failures++;
		$display("CHECK FAILED watchdog expected done seen running");
		results();
	end
	initial begin
		failures = 0;
		checks = 0;
		nrst = 1'b0;
		cmd_valid = 1'b0;
		cmd_op = HTS_OP_START;
		cmd_data = 8'h00;
		cmd_nack = 1'b0;
		straps = 5'h0f;
		for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
		repeat (10) @(posedge clock);
		// A board holds reset far longer; the strap flops need two clock edges.
		#1 nrst = 1'b1;
		repeat (3) @(posedge clock);
		#1 straps = 5'h10;
		chk("slave address", 8'h0f, {1'b0, slave_addr});
		op(HTS_OP_START, 8'h00, 1'b0);
		wr(8'h1e, 1'b0);
		wr(8'h10, 1'b0);
		wr(8'ha5, 1'b0);
		wr(8'h3c, 1'b0);
		chk("pointer", 8'h12, ptr);
		op(HTS_OP_STOP, 8'h00, 1'b0);
		chk("stored first", 8'ha5, mem[8'h10]);
		chk("stored second", 8'h3c, mem[8'h11]);
		chk("pointer after stop", 8'h00, ptr);
		chk("idle lines", 8'h03, {6'h00, bus.scl, bus.sda});
		op(HTS_OP_START, 8'h00, 1'b0);
		wr(8'h1f, 1'b0);
		rd(1'b0, 8'h5a);
		rd(1'b1, 8'h5b);
		op(HTS_OP_STOP, 8'h00, 1'b0);
		op(HTS_OP_START, 8'h00, 1'b0);
		wr(8'h1e, 1'b0);
		wr(8'h20, 1'b0);
		op(HTS_OP_START, 8'h00, 1'b0);
		wr(8'h1f, 1'b0);
		rd(1'b0, 8'h7a);
		rd(1'b1, 8'h7b);
		op(HTS_OP_START, 8'h00, 1'b0);
		wr(8'h1e, 1'b0);
		wr(8'h77, 1'b0);
		op(HTS_OP_STOP, 8'h00, 1'b0);
		chk("write after read", 8'h77, mem[8'h22]);
		op(HTS_OP_START, 8'h00, 1'b0);
		wr(8'h20, 1'b1);
		wr(8'h05, 1'b1);
		op(HTS_OP_STOP, 8'h00, 1'b0);
		chk("foreign untouched", 8'h5f, mem[8'h05]);
		op(HTS_OP_START, 8'h00, 1'b0);
		wr(8'h1f, 1'b0);
		rd(1'b1, 8'h5a);
		op(HTS_OP_STOP, 8'h00, 1'b0);
		results();
	end
endmodule : tb_top
